// ### design/clk_mode_pkg.sv
`default_nettype none
package clk_mode_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FLAG_OFS = 8'h04;
  localparam logic [7:0] PLL_OFS = 8'h08;
  localparam logic [7:0] MODE_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // ctrl register fields (masks)
  localparam int CTRL_ALT_MASK_POS = 8;
  localparam int CTRL_DIV16_MASK_POS = 9;
  localparam int CTRL_LOCK_MASK_POS = 7;
  localparam int CTRL_STOP_MASK_POS = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // flag register fields
  localparam int FLAG_PLL_SEL_POS = 0;
  localparam int FLAG_LOCK_POS = 1;
  localparam int FLAG_DIV16_N_POS = 3;
  localparam int FLAG_ALT_SEL_POS = 4;
  localparam int FLAG_WAIT_SEL_POS = 5;
  localparam int FLAG_LPW_OPT_POS = 6;
  localparam int FLAG_AUTO_OFF_POS = 7;
  localparam int FLAG_ALT_I_POS = 8;
  localparam int FLAG_DIV16_I_POS = 9;
  localparam int FLAG_LOCK_I_POS = 10;
  localparam int FLAG_STOP_I_POS = 11;
  localparam int FLAG_HALVE_POS = 15;
  // pll register fields
  localparam int PLL_DIV_POS = 0;
  localparam int PLL_MUL_POS = 4;
  localparam logic [1:0] PLL_MUL_RESET = 2'h0;
  localparam logic [2:0] PLL_DIV_RESET = 3'h7;
  localparam logic [2:0] PLL_DIV_OFF = 3'h7;
  // mode register fields
  localparam int MODE_SLEEP_POS = 0;
  localparam int MODE_STOP_POS = 1;
  // timing
  localparam int STOP_WAKE_OSC_PERIODS = 2048;
  localparam int STOP_GUARD_EXTRA = 6;
  localparam logic [11:0] STOP_WAKE_CYCLES = 12'(STOP_WAKE_OSC_PERIODS - 1);
  localparam logic [4:0] STOP_ENTRY_LEN = 5'h02;
  localparam logic [4:0] STOP_GUARD_CYCLES = 5'(STOP_ENTRY_LEN + 5'(STOP_GUARD_EXTRA));
  localparam logic [3:0] DIV16_LAST = 4'hF;

  typedef enum logic [2:0] {
    SRC_HALVED,
    SRC_DIV16,
    SRC_PLL,
    SRC_ALT,
    SRC_OFF
  } root_src_t;

  typedef enum {
    RUN,
    SLEEP,
    LP_SLEEP,
    STOP_ENTRY,
    STOPPED,
    STOP_WAKE
  } pm_state_t;

  typedef struct packed {
    logic [1:0] mul;
    logic [2:0] div;
    logic on;
  } pll_cfg_t;

  typedef struct packed {
    logic alt;
    logic div16;
    logic lock;
    logic stop;
  } irq_vec_t;
endpackage
`default_nettype wire

// ### design/clock_mode_and_low_power_ctrl.sv
// How it works
// R1: pll select, no alt, div16 off: root is halved input times 24/20/16/12 over N.
// R2: alt select wins, then div16 select low gives /16, else pll select low halved.
// R3: plain sleep with low-power option clear leaves root source unchanged.
// R4: alt-switch flag on alt root change, div16 flag on div16 select toggle.
// R5: pll-settle flag on every lock status toggle, both directions.
// R6: stop-wake flag set when input clock restarts after stop.
// R7: each pending flag forwards a request only while its mask bit is set.
// R8: pending flags clear only when software writes 1 to them.
// R9: alt clock usable as root only when its present status is set; low-power sleep with wait select set roots alt without checking it.
// R10: divider field all ones switches the pll off.
// R11: auto-off enable turns the pll off while alt clock is root.
// R12: writing 0 to sleep bit gates core clock until interrupt acknowledged.
// R13: low-power sleep gates core, disables pll, exits on acknowledge.
// R14: low-power sleep clocks peripherals by /16 or alt per wait select.
// R15: wake from low-power /16 sleep returns root to plain halved input.
// R16: wake from low-power alt sleep keeps alt as root.
// R17: stop halts root, pll off, keeps state except pll select and stop flag.
// R18: stop lasts until an external wake-up line asserts.
// R19: execution resumes 2048 input periods after stop wake-up.
// R20: leaving stop sets stop-wake flag, request if stop mask set.
// R21: reset while stopped restarts the clock.
// R22: wake-up within N+6 cycles of stop entry start is ignored.
// R23: halved input is input/2 when halve bit set (reset), else input.
// R24: pll root only when locked and regulator ok, else fall back to halved.
// R25: reset gives halved root, multiplier 00, divider 111, alt and wait selects 0.
`default_nettype none
module clock_mode_and_low_power_ctrl
  import clk_mode_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pll_locked,
  input wire logic regulator_ok,
  input wire logic alt_clock_present_status,
  input wire logic irq_ack,
  input wire logic wake_line,
  output root_src_t root_src,
  output pll_cfg_t pll_cfg,
  output logic [4:0] pll_ratio_mul,
  output logic halved_input_clock_en,
  output logic div16_tick,
  output logic core_clock_en,
  output logic periph_clock_en,
  output irq_vec_t irq_req
);
  logic [31:0] ctrl_q;
  logic pll_select_bit_q;
  logic div16_select_n_q;
  logic alt_clock_select_q;
  logic wait_clock_select_q;
  logic low_power_wait_option_q;
  logic pll_auto_off_enable_q;
  logic input_halve_bit_q;
  logic [1:0] pll_multiplier_field_q;
  logic [2:0] pll_divider_field_q;
  irq_vec_t pend_q;
  irq_vec_t set_ev;
  irq_vec_t clr_ev;
  pm_state_t state_q;
  logic [11:0] wake_cnt_q;
  logic [4:0] guard_cnt_q;
  logic halve_ph_q;
  logic [3:0] div16_cnt_q;
  logic lock_q;
  logic alt_root_q;
  logic div16_q;
  logic wr;
  logic rd_ok;
  logic alt_ok;
  logic pll_on;
  logic alt_root;
  logic sleep_wr;
  logic stop_wr;

  assign wr = psel && penable && pwrite;
  // every register answers in its access cycle, so no wait state is ever inserted
  assign pready = 1'b1;
  assign rd_ok = paddr == CTRL_OFS || paddr == FLAG_OFS ||
    paddr == PLL_OFS || paddr == MODE_OFS ||
    paddr == STATUS_OFS;
  assign pslverr = psel && penable && !rd_ok;
  assign sleep_wr = wr && paddr == MODE_OFS && !pwdata[MODE_SLEEP_POS]; // R12
  assign stop_wr = wr && paddr == MODE_OFS && pwdata[MODE_STOP_POS];

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RESET;
      pll_multiplier_field_q <= PLL_MUL_RESET; // R25
      pll_divider_field_q <= PLL_DIV_RESET; // R25
    end
    else
    begin
      if (wr && paddr == CTRL_OFS)
        ctrl_q <= pwdata & ((32'h1 << CTRL_ALT_MASK_POS) | (32'h1 << CTRL_DIV16_MASK_POS) |
          (32'h1 << CTRL_LOCK_MASK_POS) | (32'h1 << CTRL_STOP_MASK_POS));
      if (wr && paddr == PLL_OFS)
      begin
        pll_multiplier_field_q <= pwdata[PLL_MUL_POS +: 2];
        pll_divider_field_q <= pwdata[PLL_DIV_POS +: 3];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_select_bit_q <= 1'b0;
      div16_select_n_q <= 1'b1;
      alt_clock_select_q <= 1'b0;
      wait_clock_select_q <= 1'b0;
      low_power_wait_option_q <= 1'b0;
      pll_auto_off_enable_q <= 1'b0;
      input_halve_bit_q <= 1'b1; // R23
    end
    else
    begin
      if (wr && paddr == FLAG_OFS)
      begin
        pll_select_bit_q <= pwdata[FLAG_PLL_SEL_POS];
        div16_select_n_q <= pwdata[FLAG_DIV16_N_POS];
        alt_clock_select_q <= pwdata[FLAG_ALT_SEL_POS];
        wait_clock_select_q <= pwdata[FLAG_WAIT_SEL_POS];
        low_power_wait_option_q <= pwdata[FLAG_LPW_OPT_POS];
        pll_auto_off_enable_q <= pwdata[FLAG_AUTO_OFF_POS];
        input_halve_bit_q <= pwdata[FLAG_HALVE_POS];
      end
      if (state_q == STOP_ENTRY)
        pll_select_bit_q <= 1'b0; // R17
      if (state_q == LP_SLEEP && irq_ack && !wait_clock_select_q)
        div16_select_n_q <= 1'b1; // R15
      if (state_q == LP_SLEEP && irq_ack && wait_clock_select_q)
        alt_clock_select_q <= 1'b1; // R16
    end
  end

  // power mode sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= RUN; // R21
      guard_cnt_q <= '0;
      wake_cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        RUN:
        begin
          if (stop_wr)
          begin
            state_q <= STOP_ENTRY;
            guard_cnt_q <= '0;
          end
          else if (sleep_wr)
            state_q <= low_power_wait_option_q ? LP_SLEEP : SLEEP; // R3
        end
        SLEEP:
          if (irq_ack)
            state_q <= RUN; // R12
        LP_SLEEP:
          if (irq_ack)
            state_q <= RUN; // R13
        STOP_ENTRY:
        begin
          // wake lines are not looked at here, which gives the guard time
          guard_cnt_q <= guard_cnt_q + 5'h01;
          if (guard_cnt_q == STOP_GUARD_CYCLES - 5'h01)
            state_q <= STOPPED; // R22
        end
        STOPPED:
          if (wake_line)
          begin
            state_q <= STOP_WAKE; // R18
            wake_cnt_q <= '0;
          end
        STOP_WAKE:
        begin
          wake_cnt_q <= wake_cnt_q + 12'h001;
          if (wake_cnt_q == STOP_WAKE_CYCLES)
            state_q <= RUN; // R19
        end
      endcase
    end
  end

  // clock dividers as enables
  // both dividers hold in stop, so their phase carries across it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      halve_ph_q <= 1'b0;
      div16_cnt_q <= '0;
    end
    else if (state_q != STOPPED)
    begin
      halve_ph_q <= ~halve_ph_q;
      if (halved_input_clock_en)
        div16_cnt_q <= div16_cnt_q + 4'h1;
    end
  end
  assign halved_input_clock_en = (state_q != STOPPED) &&
    (!input_halve_bit_q || halve_ph_q); // R23
  assign div16_tick = halved_input_clock_en && div16_cnt_q == DIV16_LAST;

  // root selection
  assign alt_ok = alt_clock_select_q && alt_clock_present_status; // R9
  assign pll_on = pll_divider_field_q != PLL_DIV_OFF && // R10
    !(pll_auto_off_enable_q && alt_ok) && // R11
    state_q != LP_SLEEP && state_q != STOP_ENTRY && // R13
    state_q != STOPPED && state_q != STOP_WAKE; // R17
  always_comb
  begin
    if (state_q == STOPPED || state_q == STOP_WAKE)
      root_src = SRC_OFF; // R17
    else if (state_q == LP_SLEEP)
      root_src = wait_clock_select_q ? SRC_ALT : SRC_DIV16; // R14
    else if (alt_ok)
      root_src = SRC_ALT; // R2
    else if (!div16_select_n_q)
      root_src = SRC_DIV16; // R2
    else if (pll_select_bit_q && pll_on && pll_locked && regulator_ok)
      root_src = SRC_PLL; // R1 R24
    else
      root_src = SRC_HALVED; // R2 R24
  end
  assign alt_root = root_src == SRC_ALT;
  always_comb
  begin
    unique case (pll_multiplier_field_q) // R1
      2'h2: pll_ratio_mul = 5'h18;
      2'h0: pll_ratio_mul = 5'h14;
      2'h3: pll_ratio_mul = 5'h10;
      2'h1: pll_ratio_mul = 5'h0C;
    endcase
  end
  assign pll_cfg = '{mul: pll_multiplier_field_q, div: pll_divider_field_q, on: pll_on};
  // sleep only gates the core, peripherals keep their enable
  assign core_clock_en = state_q == RUN;
  assign periph_clock_en = state_q != STOPPED && state_q != STOP_WAKE && state_q != STOP_ENTRY;

  // event detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_q <= 1'b0;
      alt_root_q <= 1'b0;
      div16_q <= 1'b1;
    end
    else
    begin
      lock_q <= pll_locked;
      alt_root_q <= alt_root;
      div16_q <= div16_select_n_q;
    end
  end
  // each toggle is seen against last cycle's copy, so a flag sets one cycle late
  always_comb
  begin
    set_ev.alt = alt_root != alt_root_q; // R4
    set_ev.div16 = div16_select_n_q != div16_q; // R4
    set_ev.lock = pll_locked != lock_q; // R5
    set_ev.stop = state_q == STOP_WAKE && wake_cnt_q == STOP_WAKE_CYCLES; // R6 R20
  end
  always_comb
  begin
    clr_ev.alt = wr && paddr == FLAG_OFS && pwdata[FLAG_ALT_I_POS];
    clr_ev.div16 = wr && paddr == FLAG_OFS && pwdata[FLAG_DIV16_I_POS];
    clr_ev.lock = wr && paddr == FLAG_OFS && pwdata[FLAG_LOCK_I_POS];
    clr_ev.stop = wr && paddr == FLAG_OFS && pwdata[FLAG_STOP_I_POS];
  end

  // set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_q <= '0;
    else
      pend_q <= set_ev | (pend_q & ~clr_ev); // R8
  end
  always_comb
  begin
    irq_req.alt = pend_q.alt && ctrl_q[CTRL_ALT_MASK_POS]; // R7
    irq_req.div16 = pend_q.div16 && ctrl_q[CTRL_DIV16_MASK_POS]; // R7
    irq_req.lock = pend_q.lock && ctrl_q[CTRL_LOCK_MASK_POS]; // R7
    irq_req.stop = pend_q.stop && ctrl_q[CTRL_STOP_MASK_POS]; // R7 R20
  end

  // read mux
  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFS: prdata = ctrl_q;
      FLAG_OFS:
      begin
        prdata[FLAG_PLL_SEL_POS] = pll_select_bit_q;
        prdata[FLAG_LOCK_POS] = pll_locked;
        prdata[FLAG_DIV16_N_POS] = div16_select_n_q;
        prdata[FLAG_ALT_SEL_POS] = alt_clock_select_q;
        prdata[FLAG_WAIT_SEL_POS] = wait_clock_select_q;
        prdata[FLAG_LPW_OPT_POS] = low_power_wait_option_q;
        prdata[FLAG_AUTO_OFF_POS] = pll_auto_off_enable_q;
        prdata[FLAG_ALT_I_POS] = pend_q.alt;
        prdata[FLAG_DIV16_I_POS] = pend_q.div16;
        prdata[FLAG_LOCK_I_POS] = pend_q.lock;
        prdata[FLAG_STOP_I_POS] = pend_q.stop;
        prdata[FLAG_HALVE_POS] = input_halve_bit_q;
      end
      PLL_OFS:
      begin
        prdata[PLL_DIV_POS +: 3] = pll_divider_field_q;
        prdata[PLL_MUL_POS +: 2] = pll_multiplier_field_q;
      end
      MODE_OFS: prdata[MODE_SLEEP_POS] = state_q == RUN;
      STATUS_OFS:
      begin
        prdata[2:0] = root_src;
        prdata[3] = pll_on;
        prdata[4] = alt_clock_present_status;
      end
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule
`default_nettype wire

// ### verification/clk_mode_partner.sv
`default_nettype none
module clk_mode_partner
  import clk_mode_pkg::*;
#(
  parameter int ACK_DELAY = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire irq_vec_t irq_req,
  input wire logic core_clock_en,
  output logic irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_q;
  // acks only a sleeping core; a delay of 0 answers on the clock after the request
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wait_q <= 8'h00;
      irq_ack <= 1'b0;
    end
    else
    begin
      irq_ack <= !core_clock_en && irq_req != 4'h0 && wait_q == 8'(ACK_DELAY);
      if (core_clock_en)
        wait_q <= 8'h00;
      else if (irq_req != 4'h0 && wait_q != 8'(ACK_DELAY))
        wait_q <= wait_q + 8'h01;
    end
endmodule
`default_nettype wire

// ### verification/clk_mode_assertions.sv
`default_nettype none
module clk_mode_assertions
  import clk_mode_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic pll_locked,
  input wire logic regulator_ok,
  input wire logic irq_ack,
  input wire root_src_t root_src,
  input wire pll_cfg_t pll_cfg,
  input wire logic core_clock_en,
  input wire logic periph_clock_en,
  input wire irq_vec_t irq_req
);
  logic [3:0] mask_q;
  logic [15:0] low_q;
  wire logic mapped;
  wire logic [3:0] unmasked;
  assign mapped = paddr inside {CTRL_OFS, FLAG_OFS, PLL_OFS, MODE_OFS, STATUS_OFS};
  assign unmasked = irq_req & ~{mask_q[1], mask_q[2], mask_q[0], mask_q[3]};
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // mask copy tracks bus writes, so no design internals are needed
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mask_q <= 4'h0;
    else if (psel && penable && pwrite && paddr == CTRL_OFS)
      mask_q <= pwdata[10:7];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_q <= 16'h0;
    else if (periph_clock_en)
      low_q <= 16'h0;
    else if (low_q != 16'hFFFF)
      low_q <= low_q + 16'h1;
  sequence stop_held;
    $fell(periph_clock_en) ##1 !periph_clock_en [*8];
  endsequence
  sequence stop_exit;
    $rose(periph_clock_en) && low_q != 16'h0;
  endsequence
  property pll_root_ok;
    root_src == SRC_PLL |-> regulator_ok && (pll_locked || $past(pll_locked));
  endproperty
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped not refused");
  a_irq_masked: assert property ($stable(mask_q) |-> unmasked == 4'h0)
    else $error("unmasked request");
  a_lock_flag: assert property (mask_q[0] && $changed(pll_locked) |-> ##[1:2] irq_req.lock)
    else $error("lock toggle lost");
  a_pll_lock: assert property (pll_root_ok)
    else $error("pll root unlocked");
  a_div_off: assert property (pll_cfg.div == PLL_DIV_OFF |-> !pll_cfg.on)
    else $error("pll not off");
  a_sleep_exit: assert property (!core_clock_en && periph_clock_en && irq_ack |=> core_clock_en)
    else $error("no wake on ack");
  a_stop_pll_off: assert property (stop_held |-> !pll_cfg.on)
    else $error("pll on in stop");
  a_stop_wake_len: assert property (stop_exit |-> low_q >= 16'h0800)
    else $error("stop exit early");
  a_stop_flag: assert property (mask_q[3] ##0 stop_exit |-> ##[0:1] irq_req.stop)
    else $error("stop flag missing");
endmodule
bind clock_mode_and_low_power_ctrl clk_mode_assertions clk_mode_assertions_inst (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pslverr(pslverr),
  .pll_locked(pll_locked),
  .regulator_ok(regulator_ok),
  .irq_ack(irq_ack),
  .root_src(root_src),
  .pll_cfg(pll_cfg),
  .core_clock_en(core_clock_en),
  .periph_clock_en(periph_clock_en),
  .irq_req(irq_req)
);
`default_nettype wire

// ### verification/clock_mode_and_low_power_ctrl_tb_top.sv
`default_nettype none
module clock_mode_and_low_power_ctrl_tb_top
  import clk_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pll_locked = 1'b0, regulator_ok = 1'b0, alt_clock_present_status = 1'b0;
  logic wake_line = 1'b0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, perr, irq_ack, halved_input_clock_en, core_clock_en, periph_clock_en;
  logic div16_tick;
  logic [4:0] pll_ratio_mul;
  root_src_t root_src;
  pll_cfg_t pll_cfg;
  irq_vec_t irq_req;
  int n_errors = 0, tests_run = 0, cyc = 0, n, m;
  localparam logic [4:0] MUL_TAB [4] = '{5'h14, 5'h0C, 5'h18, 5'h10};
  clock_mode_and_low_power_ctrl clock_mode_and_low_power_ctrl_inst (.*);
  clk_mode_partner #(.ACK_DELAY(4)) clk_mode_partner_inst (.*);
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // ends at a negedge so outputs are settled for the caller
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  task automatic wait_core();
    n = 0;
    while (core_clock_en !== 1'b1 && n < 4000)
    begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic t_reset();
    rd(FLAG_OFS, 32'h8008);
    rd(PLL_OFS, 32'h7);
    rd(8'h14, 32'h0);
    chk(perr, 1'b1);
    chk(root_src, SRC_HALVED);
    chk(pready, 1'b1);
    n = 0;
    m = 0;
    repeat (64)
    begin
      @(negedge pclk);
      n += 32'(halved_input_clock_en);
      m += 32'(div16_tick);
    end
    chk(n, 32);
    chk(m, 2);
  endtask
  task automatic t_pll();
    apb(1'b1, CTRL_OFS, 32'h80);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, PLL_OFS, 32'(i) << PLL_MUL_POS);
      chk(pll_ratio_mul, MUL_TAB[i]);
    end
    @(posedge pclk);
    pll_locked <= 1'b1;
    regulator_ok <= 1'b1;
    apb(1'b1, FLAG_OFS, 32'h8009);
    chk(root_src, SRC_PLL);
    chk(irq_req.lock, 1'b1);
    apb(1'b1, PLL_OFS, 32'h37);
    chk(pll_cfg.on, 1'b0);
    @(posedge pclk);
    pll_locked <= 1'b0;
    repeat (2) @(negedge pclk);
    chk(root_src, SRC_HALVED);
    rd(FLAG_OFS, 32'h8409);
    apb(1'b1, FLAG_OFS, 32'h8009);
    rd(FLAG_OFS, 32'h8409);
    apb(1'b1, FLAG_OFS, 32'h8409);
    rd(FLAG_OFS, 32'h8009);
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b1, PLL_OFS, 32'h0);
  endtask
  task automatic t_div16();
    apb(1'b1, CTRL_OFS, 32'h200);
    apb(1'b1, FLAG_OFS, 32'h8000);
    chk(root_src, SRC_DIV16);
    // the flag sets one cycle after the select toggles
    @(negedge pclk);
    chk(irq_req.div16, 1'b1);
    apb(1'b1, MODE_OFS, 32'h0);
    chk(core_clock_en, 1'b0);
    chk(root_src, SRC_DIV16);
    wait_core();
    chk(n < 20, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0);
    chk(irq_req.div16, 1'b0);
  endtask
  task automatic t_alt();
    apb(1'b1, FLAG_OFS, 32'h8F18);
    chk(root_src, SRC_HALVED);
    apb(1'b1, FLAG_OFS, 32'h8F08);
    @(posedge pclk);
    alt_clock_present_status <= 1'b1;
    apb(1'b1, FLAG_OFS, 32'h8098);
    chk(root_src, SRC_ALT);
    chk(pll_cfg.on, 1'b0);
    rd(FLAG_OFS, 32'h8198);
    apb(1'b1, CTRL_OFS, 32'h100);
    apb(1'b1, FLAG_OFS, 32'h80F8);
    apb(1'b1, MODE_OFS, 32'h0);
    chk(core_clock_en, 1'b0);
    chk(periph_clock_en, 1'b1);
    chk(root_src, SRC_ALT);
    wait_core();
    chk(root_src, SRC_ALT);
    apb(1'b1, FLAG_OFS, 32'h8048);
    apb(1'b1, MODE_OFS, 32'h0);
    chk(pll_cfg.on, 1'b0);
    chk(root_src, SRC_DIV16);
    wait_core();
    chk(root_src, SRC_HALVED);
  endtask
  task automatic t_stop();
    apb(1'b1, FLAG_OFS, 32'h8F09);
    apb(1'b1, CTRL_OFS, 32'h400);
    apb(1'b1, MODE_OFS, 32'h2);
    @(posedge pclk);
    wake_line <= 1'b1;
    @(posedge pclk);
    wake_line <= 1'b0;
    repeat (20) @(negedge pclk);
    chk(periph_clock_en, 1'b0);
    chk(pll_cfg.on, 1'b0);
    @(posedge pclk);
    wake_line <= 1'b1;
    wait_core();
    // wake is sampled one edge after it is driven
    chk(n >= 2047 && n <= 2051, 1'b1);
    chk(irq_req.stop, 1'b1);
    @(posedge pclk);
    wake_line <= 1'b0;
    apb(1'b0, FLAG_OFS, 32'h0);
    chk(rdata & 32'h801, 32'h800);
    apb(1'b1, MODE_OFS, 32'h2);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(core_clock_en, 1'b1);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pll();
    t_div16();
    t_alt();
    t_stop();
    print_verdict();
  end
endmodule
`default_nettype wire
